// >>> vos_pkg.sv
// Purpose: constants and carriers for the video overlay scaler
// Assumes: one 10 MHz clock, registers over AXI4-Lite
// Notes: steps are 8.8 fixed point, 0x0100 is a ratio of one
package vos_pkg;
    localparam logic [7:0] VOS_CTRL_A = 8'h00;
    localparam logic [7:0] VOS_STAT_A = 8'h04;
    localparam logic [7:0] VOS_VSTEP_A = 8'h08;
    localparam logic [7:0] VOS_HSTEP_A = 8'h0c;
    localparam logic [7:0] VOS_WPOS_A = 8'h10;
    localparam logic [7:0] VOS_WSIZE_A = 8'h14;
    localparam logic [7:0] VOS_START_A = 8'h18;
    localparam logic [7:0] VOS_PITCH_A = 8'h1c;
    localparam logic [7:0] VOS_KEY_A = 8'h20;
    localparam logic [7:0] VOS_BRIGHT_A = 8'h24;
    localparam int VOS_C_OVL = 0;
    localparam int VOS_C_KEY = 1;
    localparam int VOS_C_SHARP = 2;
    localparam int VOS_C_ILACE = 3;
    localparam int VOS_C_SAT = 4;
    localparam int VOS_C_HUE = 6;
    localparam int VOS_S_FIELD = 16;
    localparam int VOS_S_UNDER = 17;
    localparam logic [31:0] VOS_CTRL_RST = 32'h0000_0000;
    localparam logic [15:0] VOS_STEP_RST = 16'h0100;
    localparam logic [7:0] VOS_HALF_LINE = 8'h80;
    localparam logic [1:0] VOS_OKAY = 2'b00;
    localparam logic [1:0] VOS_SLVERR = 2'b10;
    localparam logic signed [19:0] VOS_YOFS = 20'sh10;
    localparam logic signed [19:0] VOS_COFS = 20'sh80;
    localparam logic signed [19:0] VOS_KY = 20'sh12a;
    localparam logic signed [19:0] VOS_KRV = 20'sh199;
    localparam logic signed [19:0] VOS_KGU = 20'sh64;
    localparam logic signed [19:0] VOS_KGV = 20'shd0;
    localparam logic signed [19:0] VOS_KBU = 20'sh204;
    typedef struct packed {
        logic [7:0] y;
        logic [7:0] c;
    } vos_yc_t;
    typedef struct packed {
        logic [7:0] r;
        logic [7:0] g;
        logic [7:0] b;
    } vos_rgb_t;
endpackage

// >>> vos_overlay.sv
// Purpose: overlay scaler from fetched YUV lines to composed pixels
// Assumes: display path gives x, y with each graphics pixel
// Notes: one source pixel at most is taken per display pixel
`timescale 1ns/1ps
`default_nettype none
module vos_overlay
    import vos_pkg::*;
#(
    parameter int MAXW = 2048
)
(
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // AXI4-Lite register slave
    input wire logic [7:0] axi_awaddr_in,
    input wire logic axi_awvalid_in,
    output logic axi_awready_out,
    input wire logic [31:0] axi_wdata_in,
    input wire logic [3:0] axi_wstrb_in,
    input wire logic axi_wvalid_in,
    output logic axi_wready_out,
    output logic [1:0] axi_bresp_out,
    output logic axi_bvalid_out,
    input wire logic axi_bready_in,
    input wire logic [7:0] axi_araddr_in,
    input wire logic axi_arvalid_in,
    output logic axi_arready_out,
    output logic [31:0] axi_rdata_out,
    output logic [1:0] axi_rresp_out,
    output logic axi_rvalid_out,
    input wire logic axi_rready_in,
    // Memory controller side
    output logic fetch_req_out,
    output logic [31:0] fetch_addr_out,
    input wire logic src_valid_in,
    input wire vos_yc_t src_pix_in,
    output logic src_ready_out,
    // Graphics in, composed pixels out
    input wire logic gfx_valid_in,
    input wire logic [11:0] gfx_x_in,
    input wire logic [11:0] gfx_y_in,
    input wire vos_rgb_t gfx_pix_in,
    output logic disp_valid_out,
    output vos_rgb_t disp_pix_out
);
    localparam int AW = $clog2(MAXW);

    typedef struct packed {
        logic [31:0] ctrl;
        logic [15:0] vstep;
        logic [15:0] hstep;
        logic [31:0] wpos;
        logic [31:0] wsize;
        logic [31:0] start;
        logic [31:0] pitch;
        logic [23:0] key;
        logic [23:0] bright;
        logic aw_got;
        logic [7:0] awaddr;
        logic w_got;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic field;
        logic [19:0] vpos;
        logic lb_wr;
        logic [7:0] hfrac;
        logic [1:0] prime;
        logic [11:0] sx;
        logic cpar;
        logic [7:0] cb;
        logic [7:0] cr;
        logic [7:0] y0;
        logic [7:0] y1;
        vos_rgb_t p0;
        vos_rgb_t p1;
        logic under;
        logic fetch;
        logic [31:0] faddr;
        logic dvalid;
        vos_rgb_t dpix;
    } vos_st_t;

    vos_st_t s;
    vos_st_t n;
    logic [15:0] lbuf [MAXW];

    function automatic logic [7:0] lerp(input logic [7:0] a,
        input logic [7:0] b, input logic [7:0] w);
        logic [16:0] t;
        t = 17'(a * (9'h100 - {1'b0, w})) + 17'(b * w);
        return t[15:8];
    endfunction

    function automatic logic [7:0] clamp8(input logic signed [19:0] v);
        if (v < 0)
        begin
            return 8'h00;
        end
        if (v > 20'sh0ff)
        begin
            return 8'hff;
        end
        return v[7:0];
    endfunction

    function automatic logic signed [19:0] sx8(input logic [7:0] v);
        return $signed({12'h000, v});
    endfunction

    function automatic logic [31:0] wmerge(input logic [31:0] o,
        input logic [31:0] d, input logic [3:0] st);
        logic [31:0] r;
        r = o;
        for (int i = 0; i < 4; i++)
        begin
            if (st[i])
            begin
                r[i*8 +: 8] = d[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // Window and line events
    logic [11:0] wx, wy, ww, wh;
    logic [12:0] xe, ye;
    logic yin, in_win, lsw, fsw, fs;
    assign wx = s.wpos[11:0];
    assign wy = s.wpos[27:16];
    assign ww = s.wsize[11:0];
    assign wh = s.wsize[27:16];
    assign xe = {1'b0, wx} + {1'b0, ww};
    assign ye = {1'b0, wy} + {1'b0, wh};
    assign yin = gfx_y_in >= wy && {1'b0, gfx_y_in} < ye;
    assign in_win = gfx_valid_in && yin && gfx_x_in >= wx &&
        {1'b0, gfx_x_in} < xe;
    assign lsw = gfx_valid_in && gfx_x_in == 12'h000 && yin;
    assign fsw = lsw && gfx_y_in == wy;
    assign fs = gfx_valid_in && gfx_x_in == 12'h000 &&
        gfx_y_in == 12'h000;

    // Vertical stretch on the incoming source pixel
    vos_yc_t lb_q, vyc;
    logic [7:0] vw;
    assign lb_q = lbuf[s.sx[AW-1:0]];
    assign vw = s.vpos[7:0];
    assign vyc = '{y: lerp(lb_q.y, src_pix_in.y, vw),
        c: lerp(lb_q.c, src_pix_in.c, vw)};

    // Three tap horizontal filter on luma, centred one pixel back
    logic [9:0] smooth;
    logic signed [10:0] sharp;
    logic [7:0] yf;
    assign smooth = ({2'b00, s.y0} + {1'b0, s.y1, 1'b0}
        + {2'b00, vyc.y}) >> 2;
    assign sharp = $signed({2'b00, s.y1, 1'b0})
        - $signed({2'b00, 9'(({1'b0, s.y0} + {1'b0, vyc.y}) >> 1)});
    assign yf = s.ctrl[VOS_C_SHARP] ? clamp8(20'(sharp)) :
        smooth[7:0];

    // Colour conversion with hue and saturation sets
    logic [7:0] cbn, crn;
    logic signed [19:0] yy, cbs, crs, hk, sg, cb2, cr2, cb3, cr3;
    logic signed [19:0] rr, gr, br;
    vos_rgb_t cvt;
    assign cbn = s.cpar ? s.cb : vyc.c;
    assign crn = s.cpar ? vyc.c : s.cr;
    assign yy = ((sx8(yf) - VOS_YOFS) * VOS_KY) >>> 8;
    assign cbs = sx8(cbn) - VOS_COFS;
    assign crs = sx8(crn) - VOS_COFS;
    always_comb
    begin
        unique case (s.ctrl[VOS_C_HUE +: 2])
            2'd0: hk = 20'sh0;
            2'd1: hk = 20'sh1;
            2'd2: hk = 20'sh2;
            2'd3: hk = -20'sh1;
        endcase
        unique case (s.ctrl[VOS_C_SAT +: 2])
            2'd0: sg = 20'sh80;
            2'd1: sg = 20'sha0;
            2'd2: sg = 20'shc0;
            2'd3: sg = 20'sh60;
        endcase
    end
    assign cb2 = cbs + ((hk * crs) >>> 3);
    assign cr2 = crs - ((hk * cbs) >>> 3);
    assign cb3 = (cb2 * sg) >>> 7;
    assign cr3 = (cr2 * sg) >>> 7;
    assign rr = yy + ((VOS_KRV * cr3) >>> 8)
        + 20'($signed(s.bright[23:16]));
    assign gr = yy - ((VOS_KGU * cb3 + VOS_KGV * cr3) >>> 8)
        + 20'($signed(s.bright[15:8]));
    assign br = yy + ((VOS_KBU * cb3) >>> 8)
        + 20'($signed(s.bright[7:0]));
    assign cvt = '{clamp8(rr), clamp8(gr), clamp8(br)};

    // Horizontal stretch between the two newest RGB pixels
    vos_rgb_t vid;
    logic [8:0] hsum;
    logic hcarry, pop, show;
    assign vid = '{r: lerp(s.p0.r, s.p1.r, s.hfrac),
        g: lerp(s.p0.g, s.p1.g, s.hfrac),
        b: lerp(s.p0.b, s.p1.b, s.hfrac)};
    assign hsum = {1'b0, s.hfrac} + {1'b0, s.hstep[7:0]};
    assign hcarry = hsum[8] || s.hstep[15:8] != 8'h00;
    assign src_ready_out = s.prime != 2'd0 || (in_win && hcarry);
    assign pop = src_ready_out && src_valid_in;
    assign show = s.ctrl[VOS_C_OVL] && in_win &&
        (!s.ctrl[VOS_C_KEY] || gfx_pix_in == s.key);

    // Vertical position for the line now starting
    logic [19:0] vnew, vnext;
    logic [11:0] lnext;
    always_comb
    begin
        if (fsw)
        begin
            vnew = {12'h000, (s.ctrl[VOS_C_ILACE] && s.field)
                ? VOS_HALF_LINE : 8'h00};
        end
        else
        begin
            vnew = s.vpos + {4'h0, s.vstep};
        end
        vnext = vnew + {4'h0, s.vstep};
        lnext = vnew[19:8] + 12'h001;
    end

    assign axi_awready_out = !s.aw_got && !s.bvalid;
    assign axi_wready_out = !s.w_got && !s.bvalid;
    assign axi_arready_out = !s.rvalid;

    always_comb
    begin
        n = s;
        n.fetch = 1'b0;
        if (axi_awvalid_in && axi_awready_out)
        begin
            n.aw_got = 1'b1;
            n.awaddr = {axi_awaddr_in[7:2], 2'b00};
        end
        if (axi_wvalid_in && axi_wready_out)
        begin
            n.w_got = 1'b1;
            n.wdata = axi_wdata_in;
            n.wstrb = axi_wstrb_in;
        end
        if (s.bvalid && axi_bready_in)
        begin
            n.bvalid = 1'b0;
        end
        if (s.aw_got && s.w_got)
        begin
            n.aw_got = 1'b0;
            n.w_got = 1'b0;
            n.bvalid = 1'b1;
            n.bresp = VOS_OKAY;
            unique case (s.awaddr)
                VOS_CTRL_A: n.ctrl = wmerge(s.ctrl, s.wdata, s.wstrb);
                VOS_STAT_A:
                begin
                    if (s.wstrb[2] && s.wdata[VOS_S_UNDER])
                    begin
                        n.under = 1'b0;
                    end
                end
                VOS_VSTEP_A: n.vstep = 16'(wmerge({16'h0, s.vstep},
                    s.wdata, s.wstrb));
                VOS_HSTEP_A: n.hstep = 16'(wmerge({16'h0, s.hstep},
                    s.wdata, s.wstrb));
                VOS_WPOS_A: n.wpos = wmerge(s.wpos, s.wdata, s.wstrb);
                VOS_WSIZE_A: n.wsize = wmerge(s.wsize, s.wdata, s.wstrb);
                VOS_START_A: n.start = wmerge(s.start, s.wdata, s.wstrb);
                VOS_PITCH_A: n.pitch = wmerge(s.pitch, s.wdata, s.wstrb);
                VOS_KEY_A: n.key = 24'(wmerge({8'h0, s.key},
                    s.wdata, s.wstrb));
                VOS_BRIGHT_A: n.bright = 24'(wmerge({8'h0, s.bright},
                    s.wdata, s.wstrb));
                default: n.bresp = VOS_SLVERR;
            endcase
        end
        if (s.rvalid && axi_rready_in)
        begin
            n.rvalid = 1'b0;
        end
        if (axi_arvalid_in && axi_arready_out)
        begin
            n.rvalid = 1'b1;
            n.rresp = VOS_OKAY;
            n.rdata = 32'h0000_0000;
            unique case ({axi_araddr_in[7:2], 2'b00})
                VOS_CTRL_A: n.rdata = s.ctrl;
                VOS_STAT_A: n.rdata = {14'h0, s.under, s.field,
                    4'h0, s.vpos[19:8]};
                VOS_VSTEP_A: n.rdata = {16'h0, s.vstep};
                VOS_HSTEP_A: n.rdata = {16'h0, s.hstep};
                VOS_WPOS_A: n.rdata = s.wpos;
                VOS_WSIZE_A: n.rdata = s.wsize;
                VOS_START_A: n.rdata = s.start;
                VOS_PITCH_A: n.rdata = s.pitch;
                VOS_KEY_A: n.rdata = {8'h0, s.key};
                VOS_BRIGHT_A: n.rdata = {8'h0, s.bright};
                default: n.rresp = VOS_SLVERR;
            endcase
        end
        // With interlace on the field flips per frame; with it off the field is held at 0
        if (fs)
        begin
            n.field = s.ctrl[VOS_C_ILACE] && !s.field;
        end
        if (lsw)
        begin
            n.vpos = vnew;
            n.lb_wr = vnext[19:8] != vnew[19:8];
            n.fetch = 1'b1;
            n.faddr = s.start + {20'h0, lnext} * s.pitch;
            n.prime = 2'd2;
            n.hfrac = 8'h00;
            n.sx = 12'h000;
            n.cpar = 1'b0;
        end
        else if (in_win)
        begin
            n.hfrac = hsum[7:0];
        end
        if (pop)
        begin
            n.sx = s.sx + 12'h001;
            n.cpar = !s.cpar;
            n.cb = cbn;
            n.cr = crn;
            n.y0 = s.y1;
            n.y1 = vyc.y;
            n.p0 = s.p1;
            n.p1 = cvt;
            if (s.prime != 2'd0)
            begin
                n.prime = s.prime - 2'd1;
            end
        end
        // Set wins over a clear in the same cycle
        if (src_ready_out && !src_valid_in && s.prime == 2'd0)
        begin
            n.under = 1'b1;
        end
        n.dvalid = gfx_valid_in;
        n.dpix = show ? vid : gfx_pix_in;
    end

    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            s <= '0;
            s.ctrl <= VOS_CTRL_RST;
            s.vstep <= VOS_STEP_RST;
            s.hstep <= VOS_STEP_RST;
        end
        else
        begin
            s <= n;
        end
    end

    // Line buffer keeps no reset; the first line of a frame reads stale
    always_ff @(posedge clk_in)
    begin
        if (pop && s.lb_wr)
        begin
            lbuf[s.sx[AW-1:0]] <= src_pix_in;
        end
    end

    assign axi_bresp_out = s.bresp;
    assign axi_bvalid_out = s.bvalid;
    assign axi_rdata_out = s.rdata;
    assign axi_rresp_out = s.rresp;
    assign axi_rvalid_out = s.rvalid;
    assign fetch_req_out = s.fetch;
    assign fetch_addr_out = s.faddr;
    assign disp_valid_out = s.dvalid;
    assign disp_pix_out = s.dpix;

    default clocking dc @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);

    pass_through_a: assert property (
        gfx_valid_in && !s.ctrl[VOS_C_OVL]
        |=> disp_valid_out && disp_pix_out == $past(gfx_pix_in))
        else $error("graphics not passed through");
    key_select_a: assert property (
        s.ctrl[VOS_C_OVL] && s.ctrl[VOS_C_KEY] && in_win
        && gfx_pix_in == s.key |=> disp_pix_out == $past(vid))
        else $error("keyed pixel not replaced by video");
    window_video_a: assert property (
        s.ctrl[VOS_C_OVL] && !s.ctrl[VOS_C_KEY] && in_win
        |=> disp_pix_out == $past(vid))
        else $error("window pixel not video");
    outside_gfx_a: assert property (
        gfx_valid_in && !in_win
        |=> disp_pix_out == $past(gfx_pix_in))
        else $error("video leaked outside window");
    clamp_high_a: assert property (
        rr > 20'sh0ff |-> cvt.r == 8'hff)
        else $error("red not clamped");
    bottom_half_a: assert property (
        fsw && s.ctrl[VOS_C_ILACE] && s.field
        |=> s.vpos == {12'h000, VOS_HALF_LINE})
        else $error("bottom field not offset");
    line_fetch_a: assert property (
        lsw |=> fetch_req_out ##1 !fetch_req_out)
        else $error("fetch not one pulse per line");
    stretch_zero_a: assert property (
        s.hfrac == 8'h00 |-> vid == s.p0)
        else $error("zero weight not previous pixel");
    write_resp_a: assert property (
        s.aw_got && s.w_got |=> axi_bvalid_out)
        else $error("write response missing");
    read_resp_a: assert property (
        axi_arvalid_in && axi_arready_out
        |=> axi_rvalid_out [*1] ##0 !axi_arready_out)
        else $error("read answer missing");
    reset_coef_a: assert property (
        $rose(rst_n_in) |-> s.ctrl[VOS_C_HUE +: 2] == 2'd0
        && s.ctrl[VOS_C_SAT +: 2] == 2'd0)
        else $error("coefficient set not default");
endmodule
`default_nettype wire

// >>> vos_src_model.sv
// Purpose: framebuffer memory controller stand-in for the overlay scaler
// Assumes: each fetch pulse asks for one whole source line, sent in order
// Notes: slow mode leaves four idle cycles before each pixel
`timescale 1ns/1ps
`default_nettype none
module vos_src_model
    import vos_pkg::*;
#(
    parameter int LINE_W = 16
)
(
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // Test controls
    input wire logic slow_in,
    input wire logic [7:0] level_in,
    // Overlay side
    input wire logic fetch_req_in,
    input wire logic src_ready_in,
    output logic src_valid_out,
    output vos_yc_t src_pix_out
);
    logic act_r;
    logic [1:0] gap_r;
    logic [7:0] cnt_r;
    // Neutral chroma keeps every output pixel grey
    vos_yc_t pix;
    assign pix = '{y: level_in, c: 8'h80};
    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            act_r <= 1'b0;
            gap_r <= 2'd0;
            cnt_r <= 8'h00;
            src_valid_out <= 1'b0;
            src_pix_out <= '0;
        end
        else if (fetch_req_in)
        begin
            act_r <= 1'b1;
            cnt_r <= 8'h00;
            gap_r <= 2'd0;
            src_valid_out <= !slow_in;
            src_pix_out <= slow_in ? ~src_pix_out : pix;
        end
        else if (src_valid_out && src_ready_in)
        begin
            cnt_r <= cnt_r + 8'h01;
            gap_r <= 2'd0;
            if (cnt_r == 8'(LINE_W - 1))
                act_r <= 1'b0;
            if (cnt_r == 8'(LINE_W - 1) || slow_in)
            begin
                src_valid_out <= 1'b0;
                // Released data toggles so stale values are never trusted
                src_pix_out <= ~src_pix_out;
            end
            else
                src_pix_out <= pix;
        end
        else if (act_r && !src_valid_out && gap_r == 2'd3)
        begin
            src_valid_out <= 1'b1;
            src_pix_out <= pix;
        end
        else if (!src_valid_out)
        begin
            gap_r <= gap_r + 2'd1;
            src_pix_out <= ~src_pix_out;
        end
    end
endmodule
`default_nettype wire

// >>> vos_overlay_bench.sv
// Purpose: self-checking bench for the overlay scaler
// Assumes: window at columns 6..13, rows 2..3 of a 16x6 screen
// Notes: colour, step, brightness, level and key settings run one warm-up frame before the checked one
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin num_errors++; $display("[ERR] %0t got %h exp %h", $time, (a), (b)); end end
module vos_overlay_bench
    import vos_pkg::*;
;
    logic clk, rst_n, awv, wv, bready, arv, rready, awr, wr_r, bv, arr, rv;
    logic [7:0] awa, ara, level;
    logic [31:0] wd, rdata, rd, ctrl, key;
    logic [3:0] ws;
    logic [1:0] bresp, rresp, rs;
    logic fetch, sv, sr, gv, dv, slow, f0;
    logic [31:0] faddr;
    vos_yc_t spix;
    logic [11:0] gx, gy;
    vos_rgb_t gpix, dpix, exp_vid;
    int num_errors, tests_run, cyc;
    logic [7:0] ra[8] = '{VOS_CTRL_A, VOS_VSTEP_A, VOS_HSTEP_A, VOS_WPOS_A,
        VOS_WSIZE_A, VOS_START_A, VOS_PITCH_A, VOS_BRIGHT_A};
    logic [31:0] rvv[8] = '{32'h0, 32'h100, 32'h100, 32'h0, 32'h0, 32'h0,
        32'h0, 32'h0};

    vos_overlay u_vos_overlay (.clk_in(clk), .rst_n_in(rst_n),
        .axi_awaddr_in(awa), .axi_awvalid_in(awv), .axi_awready_out(awr),
        .axi_wdata_in(wd), .axi_wstrb_in(ws), .axi_wvalid_in(wv),
        .axi_wready_out(wr_r), .axi_bresp_out(bresp), .axi_bvalid_out(bv),
        .axi_bready_in(bready), .axi_araddr_in(ara), .axi_arvalid_in(arv),
        .axi_arready_out(arr), .axi_rdata_out(rdata), .axi_rresp_out(rresp),
        .axi_rvalid_out(rv), .axi_rready_in(rready), .fetch_req_out(fetch),
        .fetch_addr_out(faddr), .src_valid_in(sv), .src_pix_in(spix),
        .src_ready_out(sr), .gfx_valid_in(gv), .gfx_x_in(gx), .gfx_y_in(gy),
        .gfx_pix_in(gpix), .disp_valid_out(dv), .disp_pix_out(dpix));
    vos_src_model u_vos_src_model (.clk_in(clk), .rst_n_in(rst_n),
        .slow_in(slow), .level_in(level), .fetch_req_in(fetch),
        .src_ready_in(sr), .src_valid_out(sv), .src_pix_out(spix));

    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic complete_run();
        $display("errors %0d checks %0d", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            num_errors++;
            complete_run();
        end
    end

    task automatic wr(input logic [7:0] a, input logic [31:0] d,
        input logic [1:0] er);
        @(posedge clk);
        gv <= 1'b0;
        awa <= a;
        wd <= d;
        ws <= 4'hf;
        awv <= 1'b1;
        wv <= 1'b1;
        bready <= 1'b1;
        // Each half drops at the edge that takes it; bresp taken with bvalid
        do
        begin
            @(posedge clk);
            if (awr)
                awv <= 1'b0;
            if (wr_r)
                wv <= 1'b0;
        end
        while (!bv);
        rs = bresp;
        bready <= 1'b0;
        `CHK(rs, er)
    endtask

    task automatic rdr(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        gv <= 1'b0;
        ara <= a;
        arv <= 1'b1;
        rready <= 1'b1;
        do
        begin
            @(posedge clk);
            if (arr)
                arv <= 1'b0;
        end
        while (!rv);
        d = rdata;
        rs = rresp;
        rready <= 1'b0;
    endtask

    // One screen of graphics; output compared one cycle after each pixel
    task automatic frame(input bit chk);
        vos_rgb_t g, e;
        logic inw, row;
        for (int y = 0; y < 6; y++)
            for (int x = 0; x < 16; x++)
            begin
                g = '{r: x[7:0], g: y[7:0], b: 8'h5a};
                gv <= 1'b1;
                gx <= x[11:0];
                gy <= y[11:0];
                gpix <= g;
                @(posedge clk);
                #1;
                row = (y >= 2 && y < 4);
                inw = ctrl[0] && row && x >= 6 && x < 14;
                e = (inw && (!ctrl[1] || g == key[23:0])) ? exp_vid : g;
                if (chk)
                    `CHK({dv, dpix}, {1'b1, e})
                if (ctrl[0] && x == 0)
                    `CHK(fetch, row)
                if (fetch)
                    `CHK((faddr - 32'h1000) % 32'h400, 32'h0)
            end
    endtask

    task automatic set_ctrl(input logic [31:0] c);
        ctrl = c;
        wr(VOS_CTRL_A, c, VOS_OKAY);
    endtask

    initial
    begin
        {awv, wv, bready, arv, rready, gv, slow} = '0;
        {awa, ara, wd, ws, gx, gy, gpix, cyc} = '0;
        num_errors = 0;
        tests_run = 0;
        rst_n = 1'b0;
        level = 8'd144;
        ctrl = 32'h0;
        key = 32'h0009_035a;
        exp_vid = '{r: 8'd149, g: 8'd149, b: 8'd149};
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 8; i++)
        begin
            rdr(ra[i], rd);
            `CHK(rd, rvv[i])
        end
        rdr(8'h28, rd);
        `CHK(rs, VOS_SLVERR)
        wr(8'h28, 32'h1, VOS_SLVERR);
        wr(VOS_WPOS_A, 32'h0002_0006, VOS_OKAY);
        wr(VOS_WSIZE_A, 32'h0002_0008, VOS_OKAY);
        wr(VOS_START_A, 32'h1000, VOS_OKAY);
        wr(VOS_PITCH_A, 32'h400, VOS_OKAY);
        wr(VOS_KEY_A, key, VOS_OKAY);
        rdr(VOS_KEY_A, rd);
        `CHK(rd, key)
        frame(1);
        // Every hue and saturation set and both filters keep grey grey
        for (int s = 0; s < 32; s++)
        begin
            set_ctrl({24'h0, s[3:0], 1'b0, s[4], 2'b01});
            frame(0);
            frame(1);
        end
        for (int k = 0; k < 2; k++)
        begin
            wr(VOS_VSTEP_A, k ? 32'h100 : 32'h80, VOS_OKAY);
            wr(VOS_HSTEP_A, k ? 32'h100 : 32'h80, VOS_OKAY);
            frame(0);
            frame(1);
        end
        wr(VOS_BRIGHT_A, 32'h0005_fb00, VOS_OKAY);
        exp_vid = '{r: 8'd154, g: 8'd144, b: 8'd149};
        frame(0);
        frame(1);
        wr(VOS_BRIGHT_A, 32'h0, VOS_OKAY);
        level <= 8'd255;
        exp_vid = '{r: 8'hff, g: 8'hff, b: 8'hff};
        frame(0);
        frame(1);
        level <= 8'd0;
        exp_vid = '0;
        frame(0);
        frame(1);
        level <= 8'd144;
        exp_vid = '{r: 8'd149, g: 8'd149, b: 8'd149};
        set_ctrl(32'h3);
        frame(0);
        frame(1);
        set_ctrl(32'h9);
        rdr(VOS_STAT_A, rd);
        f0 = rd[VOS_S_FIELD];
        frame(1);
        rdr(VOS_STAT_A, rd);
        `CHK(rd[VOS_S_FIELD], ~f0)
        frame(1);
        rdr(VOS_STAT_A, rd);
        `CHK(rd[VOS_S_FIELD], f0)
        set_ctrl(32'h1);
        // Starved source must be flagged, then cleared by software
        slow <= 1'b1;
        frame(0);
        rdr(VOS_STAT_A, rd);
        `CHK(rd[VOS_S_UNDER], 1'b1)
        slow <= 1'b0;
        wr(VOS_STAT_A, 32'h1 << VOS_S_UNDER, VOS_OKAY);
        rdr(VOS_STAT_A, rd);
        `CHK(rd[VOS_S_UNDER], 1'b0)
        complete_run();
    end
endmodule
`undef CHK
`default_nettype wire
